// File: src/one_shot_timer.sv
// Retriggerable one-shot timer core with an AXI4-Lite register slave.
//
// Behaviour
// R1 - A qualifying trigger edge drives the output active for the pulse length.
// R2 - Pulse length is the divide ratio times the master period.
// R3 - Non-retriggerable mode ignores triggers during the pulse and rearm time.
// R4 - The source holds each trigger level at least the minimum width.
// R5 - Retriggerable mode ends one pulse length after the latest edge.
// R6 - The source spaces retriggers by at least the retrigger spacing.
// R7 - Rising or falling edge, with or without retrigger, are selectable.
// R8 - Polarity bit is the code MSB; codes 8 and up invert the output.
// R9 - A changed code is adopted after 16 times (difference plus 6) periods.
// R10 - A new code is taken only when stable, directly, skipping between values.
// R11 - A code change during a pulse may give a length between both settings.
// R12 - After reset a start-up interval holds the output low.
// R13 - Start-up lasts 500 master periods whatever the divide ratio.
// R14 - Start-up waits for a stable code before any pulse.
// R15 - Start-up ends by latching the code and setting the idle output level.
// R16 - A trigger sets the output latch; the timing chain clears it.
// R17 - Codes 0..7 give ratios 1..2^21 by powers of 8; 8..15 mirror them.
// R18 - The divider code arrives as a 4-bit quantized value.
// R19 - The pulse counts ratio master periods; a retrigger restarts the count.
// R20 - Trigger edges are found by synchronizing and comparing with the past.
//
// Design decisions made here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "one_shot_defs.svh"

module one_shot_timer
  import one_shot_pkg::*;
#(
  parameter logic [15:0] MASTER_CYCLES = 16'(`MASTER_CYCLES)
) (
  // Clock and reset.
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address and data.
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  // AXI4-Lite write response.
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // AXI4-Lite read.
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Pins.
  input  wire logic        trigger_in,
  input  wire logic [3:0]  divider_code,
  output logic             pulse_out
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations.
  seq_state_t  state;
  logic [31:0] ctrl;
  logic [15:0] mper;
  logic [15:0] pre_cnt;
  logic        tick;
  logic        trigger_in_s1, trigger_in_s2, trigger_in_prev;
  logic [3:0]  code_s1, code_s2, code_last, code_act;
  logic [8:0]  start_cnt;
  logic [8:0]  filt_cnt;
  logic [8:0]  need;
  logic [3:0]  diff;
  logic [21:0] pcnt;
  logic [21:0] limit;
  logic [7:0]  rcnt;
  logic        qual, start_done, code_moved;
  logic        aw_held, w_held, do_write;
  logic        next_aw_held, next_w_held, next_bvalid, next_rvalid;
  logic        aw_take, w_take, ar_take;
  logic [7:0]  aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0]  w_strb_q;

  // Divide ratio exponent; upper codes mirror the lower ones.
  function automatic logic [4:0] ratio_exp(input logic [3:0] c);
    logic [2:0] idx;
    idx = c[3] ? ~c[2:0] : c[2:0];
    return 5'(idx * `RATIO_STEP);
  endfunction : ratio_exp

  // Byte-lane merge of a write into an existing word.
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] val,
                                        input logic [3:0]  strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = val[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  ////////////////////////////////////////////////////////////////////////////
  // Master time base.

  // Prescaler stands in for the resistor-set oscillator period.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_cnt <= 16'h0000;
      tick    <= 1'b0;
    end else if (pre_cnt + 16'h0001 >= mper) begin  // see R2
      pre_cnt <= 16'h0000;
      tick    <= 1'b1;
    end else begin
      pre_cnt <= pre_cnt + 16'h0001;
      tick    <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers and edge detection.

  // Two flops per pin; the code bits may land skewed, the filter hides it.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      trigger_in_s1   <= 1'b0;
      trigger_in_s2   <= 1'b0;
      trigger_in_prev <= 1'b0;
      code_s1   <= 4'h0;
      code_s2   <= 4'h0;
      code_last <= 4'h0;
    end else begin
      trigger_in_s1   <= trigger_in;  // see R20
      trigger_in_s2   <= trigger_in_s1;
      trigger_in_prev <= trigger_in_s2;
      code_s1   <= divider_code;  // see R18
      code_s2   <= code_s1;
      code_last <= code_s2;
    end
  end

  // Qualifying edge follows the selected trigger sense.
  assign qual = ctrl[`CTRL_FALL] ? (trigger_in_prev & ~trigger_in_s2)   // see R7
                                 : (~trigger_in_prev & trigger_in_s2);  // see R20

  ////////////////////////////////////////////////////////////////////////////
  // Divider code filter.

  assign code_moved = (code_s2 != code_last);
  assign diff = (code_s2 > code_act) ? code_s2 - code_act
                                     : code_act - code_s2;
  assign need = 9'({`CHG_OFFSET + 5'(diff), 4'h0});  // see R9
  assign start_done = (state == ST_START) && tick
                      && (start_cnt + 9'd1 >= `START_TICKS)  // see R13
                      && (filt_cnt >= `STABLE_TICKS)  // see R14
                      && !code_moved;

  // Any movement restarts the wait, so only a settled code is adopted.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      filt_cnt <= 9'h000;
      code_act <= 4'h0;
    end else if (code_moved) begin
      filt_cnt <= 9'h000;  // see R10
    end else if (state == ST_START) begin
      if (start_done) begin
        code_act <= code_s2;  // see R15
        filt_cnt <= 9'h000;
      end else if (tick && filt_cnt < `STABLE_TICKS) begin
        filt_cnt <= filt_cnt + 9'd1;
      end
    end else if (code_s2 == code_act) begin
      filt_cnt <= 9'h000;
    end else if (tick) begin
      if (filt_cnt + 9'd1 >= need) begin
        code_act <= code_s2;  // see R10
        filt_cnt <= 9'h000;
      end else begin
        filt_cnt <= filt_cnt + 9'd1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Start-up counter.

  // Saturates at its end; a moving code holds start-up open past it.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      start_cnt <= 9'h000;  // see R12
    end else if (state == ST_START && tick
                 && start_cnt + 9'd1 < `START_TICKS) begin
      start_cnt <= start_cnt + 9'd1;  // see R13
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Pulse sequencer.

  // The limit follows the live code, so a change mid-pulse bends its length.
  assign limit = 22'h00_0001 << ratio_exp(code_act);  // see R17 R11

  // Latch set by the trigger, cleared by the timing chain.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_START;  // see R12
      pcnt  <= 22'h00_0000;
      rcnt  <= 8'h00;
    end else begin
      unique case (state)
        ST_START: begin
          if (start_done) begin
            state <= ST_IDLE;  // see R15
          end
        end
        ST_IDLE: begin
          if (qual) begin
            state <= ST_PULSE;  // see R1 R16
            pcnt  <= 22'h00_0000;
          end
        end
        ST_PULSE: begin
          if (qual && ctrl[`CTRL_RETRIG]) begin
            pcnt <= 22'h00_0000;  // see R5 R19
          end else if (tick) begin
            if (pcnt + 22'h00_0001 >= limit) begin  // see R2 R19
              state <= ctrl[`CTRL_RETRIG] ? ST_IDLE : ST_REARM;  // see R16
              rcnt  <= 8'h00;
            end else begin
              pcnt <= pcnt + 22'h00_0001;
            end
          end
        end
        ST_REARM: begin
          // Triggers here are dropped on purpose.
          if (tick) begin
            if (rcnt >= ctrl[`CTRL_REARM_HI:`CTRL_REARM_LO]) begin
              state <= ST_IDLE;  // see R3
            end else begin
              rcnt <= rcnt + 8'h01;
            end
          end
        end
      endcase
    end
  end

  // Output pin: low in start-up, else active level xor polarity bit.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pulse_out <= 1'b0;  // see R12
    end else if (state == ST_START) begin
      pulse_out <= 1'b0;
    end else begin
      pulse_out <= (state == ST_PULSE) ^ code_act[3];  // see R8 R15
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path.

  assign aw_take = awvalid & awready;
  assign w_take  = wvalid & wready;
  assign do_write = aw_held & w_held & ~bvalid;
  assign next_aw_held = (aw_held | aw_take) & ~do_write;
  assign next_w_held  = (w_held | w_take) & ~do_write;
  assign next_bvalid  = (bvalid & ~bready) | do_write;

  // Address and data are caught in either order; the answer follows both.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held   <= 1'b0;
      w_held    <= 1'b0;
      awready   <= 1'b0;
      wready    <= 1'b0;
      bvalid    <= 1'b0;
      bresp     <= `RESP_OKAY;
      aw_addr_q <= 8'h00;
      w_data_q  <= 32'h0000_0000;
      w_strb_q  <= 4'h0;
    end else begin
      aw_held <= next_aw_held;
      w_held  <= next_w_held;
      awready <= ~next_aw_held & ~next_bvalid;
      wready  <= ~next_w_held & ~next_bvalid;
      bvalid  <= next_bvalid;
      if (aw_take) begin
        aw_addr_q <= {awaddr[7:2], 2'b00};
      end
      if (w_take) begin
        w_data_q <= wdata;
        w_strb_q <= wstrb;
      end
      if (do_write) begin
        bresp <= (aw_addr_q == `OFS_CTRL || aw_addr_q == `OFS_MPER
                  || aw_addr_q == `OFS_STAT) ? `RESP_OKAY : `RESP_SLVERR;
      end
    end
  end

  // Writable registers; the status word ignores writes.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl <= `CTRL_RESET;
      mper <= MASTER_CYCLES;
    end else if (do_write && aw_addr_q == `OFS_CTRL) begin
      ctrl <= merge(ctrl, w_data_q, w_strb_q) & `CTRL_MASK;  // see R7
    end else if (do_write && aw_addr_q == `OFS_MPER) begin
      mper <= 16'(merge({16'h0000, mper}, w_data_q, w_strb_q));
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path.

  assign ar_take = arvalid & arready;
  assign next_rvalid = (rvalid & ~rready) | ar_take;

  // Data is sampled at the address edge and held until taken.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= `RESP_OKAY;
    end else begin
      arready <= ~next_rvalid;
      rvalid  <= next_rvalid;
      if (ar_take) begin
        rresp <= `RESP_OKAY;
        unique case ({araddr[7:2], 2'b00})
          `OFS_CTRL: rdata <= ctrl;
          `OFS_MPER: rdata <= {16'h0000, mper};
          `OFS_STAT: rdata <= {20'h0_0000, code_s2, code_act,
                               code_act[3], (state != ST_START),
                               (state == ST_REARM), (state == ST_PULSE)};
          default: begin
            rdata <= 32'h0000_0000;
            rresp <= `RESP_SLVERR;
          end
        endcase
      end
    end
  end

endmodule : one_shot_timer

// File: src/one_shot_defs.svh
// Constants of the one-shot timer: offsets, fields, resets and timing.
`ifndef ONE_SHOT_DEFS_SVH
`define ONE_SHOT_DEFS_SVH
// Register byte offsets on the AXI4-Lite bus.
`define OFS_CTRL       8'h00
`define OFS_MPER       8'h04
`define OFS_STAT       8'h08
// Control register fields.
`define CTRL_FALL      0
`define CTRL_RETRIG    1
`define CTRL_REARM_LO  8
`define CTRL_REARM_HI  15
`define CTRL_RESET     32'h0000_0100
// Writable control bits: edge sense, retrigger and rearm length.
`define CTRL_MASK      32'h0000_FF03
// Timing: master period and clock period in ns, cycles per master tick.
`define CLK_NS         10
`define MASTER_NS      1000
`define MASTER_CYCLES  (`MASTER_NS / `CLK_NS)
// Start-up length and code stability window, in master periods.
`define START_TICKS    9'd500
`define STABLE_TICKS   9'd16
// Code change delay: 16 * (difference + 6) master periods.
`define CHG_MULT       4
`define CHG_OFFSET     5'd6
// Divide ratio exponent step: each code step is a factor of 8.
`define RATIO_STEP     3
// AXI responses.
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2
`endif

// File: src/one_shot_pkg.sv
// Types shared by the one-shot timer.
package one_shot_pkg;
  // Sequencer states of the pulse generator.
  typedef enum logic [1:0] {
    ST_START = 2'b00,
    ST_IDLE  = 2'b01,
    ST_PULSE = 2'b10,
    ST_REARM = 2'b11
  } seq_state_t;
endpackage : one_shot_pkg

// File: testbench/one_shot_timer_asserts.sv
// Port checker for the one-shot timer and its bind.
`timescale 1ns/1ns
`include "one_shot_defs.svh"
////////////////////////////////////////////////////////////////////
module one_shot_timer_chk #(
  parameter logic [15:0] MASTER_CYCLES = 16'd100
) (
  // Clock and reset.
  input wire logic        aclk,
  input wire logic        aresetn,
  // Register bus.
  input wire logic [7:0]  awaddr,
  input wire logic        awvalid,
  input wire logic        awready,
  input wire logic        wvalid,
  input wire logic        wready,
  input wire logic [1:0]  bresp,
  input wire logic        bvalid,
  input wire logic        bready,
  input wire logic [7:0]  araddr,
  input wire logic        arvalid,
  input wire logic        arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0]  rresp,
  input wire logic        rvalid,
  input wire logic        rready,
  // Output pin.
  input wire logic        pulse_out
);
  logic [9:0] up_cnt;
  // Cycles since reset; a tick is never shorter than one cycle.
  always_ff @(posedge aclk) begin
    if (!aresetn) up_cnt <= 10'h000;
    else if (up_cnt != 10'h3FF) up_cnt <= up_cnt + 10'h001;
  end
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr;
    awvalid && awready && wvalid && wready;
  endsequence
  sequence s_rd;
    arvalid && arready;
  endsequence
  AST_START_LOW: assert property (up_cnt < 10'd500 |-> !pulse_out)
    else $error("Output left low level during start-up.");
  AST_B_LAT: assert property (s_wr |-> ##2 bvalid)
    else $error("Write response late.");
  AST_B_HOLD: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("Write response dropped early.");
  AST_W_BLOCK: assert property (bvalid |-> !awready && !wready)
    else $error("Write taken while response pending.");
  AST_W_ERR: assert property (s_wr ##0 awaddr > 8'h0B |-> ##2 bresp == `RESP_SLVERR)
    else $error("Unmapped write not refused.");
  AST_R_LAT: assert property (s_rd |=> rvalid)
    else $error("Read data late.");
  AST_R_HOLD: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("Read data dropped early.");
  AST_R_BLOCK: assert property (rvalid |-> !arready)
    else $error("Read taken while data pending.");
  AST_R_ERR: assert property (s_rd ##0 araddr > 8'h0B |=> rresp == `RESP_SLVERR
                              && rdata == 32'h0)
    else $error("Unmapped read not refused.");
endmodule : one_shot_timer_chk
bind one_shot_timer one_shot_timer_chk #(.MASTER_CYCLES(MASTER_CYCLES)) i_chk (
  .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
  .awready(awready), .wvalid(wvalid), .wready(wready), .bresp(bresp),
  .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
  .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
  .rready(rready), .pulse_out(pulse_out));

// File: testbench/one_shot_src.sv
// Trigger source and divider setting that face the one-shot timer pins.
`timescale 1ns/1ns
module one_shot_src (
  // Clock.
  input wire logic        aclk,
  // Bench requests.
  input wire logic        lvl_req,
  input wire logic [3:0]  code_req,
  // Timer pins.
  output logic            trigger_in,
  output logic [3:0]      divider_code
);
  logic [2:0] hold;
  initial begin
    trigger_in = 1'b0;
    hold = 3'h0;
  end
  // A level is kept five cycles before it may change, so a short glitch
  // asked for by the bench reaches the pin stretched to five cycles or not at all.
  always @(posedge aclk) begin
    if (lvl_req != trigger_in && hold >= 3'h4) begin
      trigger_in <= lvl_req;
      hold <= 3'h0;
    end else if (hold != 3'h7) hold <= hold + 3'h1;
  end
  // The code moves in one step, like a settled quantized divider input.
  assign divider_code = code_req;
endmodule : one_shot_src

// File: testbench/one_shot_timer_tb_top.sv
// Self-checking bench of the one-shot timer.
`timescale 1ns/1ns
module one_shot_timer_tb_top;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, pulse_out;
  logic        trigger_in, lvl_req;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, v, seed;
  logic [3:0]  wstrb, code_req, divider_code;
  logic [1:0]  bresp, rresp;
  int          errors, check_count, cyc, cur, m, g;
  int          codes[$] = '{1, 0, 2, 15, 13};
////////////////////////////////////////////////////////////////////
  one_shot_timer i_dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
    .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .trigger_in(trigger_in), .divider_code(divider_code),
    .pulse_out(pulse_out));
  one_shot_src i_src (.aclk(aclk), .lvl_req(lvl_req), .code_req(code_req),
    .trigger_in(trigger_in), .divider_code(divider_code));
  // Clock and free-running cycle count.
  always #5 aclk = ~aclk;
  always @(posedge aclk) cyc <= cyc + 1;
  // Pulse length model: eight-fold steps, mirrored above code 7.
  function automatic int lim(input int c);
    return 1 << (3 * (c[3] ? 7 - (c & 7) : (c & 7)));
  endfunction : lim
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      errors++;
      $display("ERROR %0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task give_verdict();
    if (errors == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : give_verdict
  // Bus write; both channels offered together, bready up until answered.
  task wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    bit done;
    awaddr <= a; wdata <= d; wstrb <= 4'hF;
    awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    done = 0;
    for (int n = 0; n < 40 && !done; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin chk(bresp, er); bready <= 1'b0; done = 1; end
    end
    if (!done) begin errors++; give_verdict(); end
    @(posedge aclk);
  endtask : wr
  task rd(input logic [7:0] a, input logic [1:0] er, output logic [31:0] d);
    bit done;
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    done = 0;
    for (int n = 0; n < 40 && !done; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin d = rdata; chk(rresp, er); rready <= 1'b0; done = 1; end
    end
    if (!done) begin errors++; give_verdict(); end
    @(posedge aclk);
  endtask : rd
  // One trigger on level e; a second same-way edge is asked for gap plus six cycles into it.
  task shot(input logic e, input int gap, input int exp, input int tol);
    int len;
    logic idle;
    idle = pulse_out;
    lvl_req <= !e;
    repeat (8) @(posedge aclk);
    lvl_req <= e;
    len = 0;
    for (int n = 0; n < 20 && pulse_out === idle; n++) @(posedge aclk);
    for (int n = 0; n < 5000 && pulse_out !== idle; n++) begin
      @(posedge aclk);
      len++;
      if (len == gap) lvl_req <= !e;
      if (len == gap + 6) lvl_req <= e;
    end
    chk((len >= exp - tol && len <= exp + tol) ? exp : len, exp);
    repeat (8) @(posedge aclk);
  endtask : shot
  // Change the code and time its adoption through the status word.
  task adopt(input int nc);
    int t0, dl, e;
    dl = 16 * ((nc > cur ? nc - cur : cur - nc) + 6);
    code_req <= nc[3:0];
    t0 = cyc;
    v = cur << 4;
    for (int n = 0; n < 300 && v[7:4] != nc; n++) begin
      rd(8'h08, 2'h0, v);
      chk((v[7:4] == nc || v[7:4] == cur) ? 1 : 0, 1);
    end
    e = cyc - t0;
    chk((e >= dl - 2 && e <= dl + 24) ? dl : e, dl);
    cur = nc;
    repeat (2) @(posedge aclk);
    chk(pulse_out, cur[3]);
  endtask : adopt
////////////////////////////////////////////////////////////////////
  // Main sequence.
  initial begin
    aclk = 0; aresetn = 0; awvalid = 0; wvalid = 0; bready = 0;
    arvalid = 0; rready = 0; awaddr = 0; araddr = 0; wdata = 0;
    wstrb = 0; lvl_req = 0; code_req = 4'hE; cur = 14; seed = 10996;
    errors = 0; check_count = 0; cyc = 0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    rd(8'h00, 2'h0, v); chk(v, 32'h0000_0100);
    rd(8'h04, 2'h0, v); chk(v, 32'h0000_0064);
    rd(8'h0C, 2'h2, v); chk(v, 32'h0);
    wr(8'h0C, 32'h0000_FFFF, 2'h2);
    wr(8'h08, 32'hFFFF_FFFF, 2'h0);
    wr(8'h04, 32'h0000_0001, 2'h0);
    v = 0;
    for (int n = 0; n < 400 && !v[2]; n++) rd(8'h08, 2'h0, v);
    chk(v[7:2], 6'h3B);
    chk(pulse_out, 1'b1);
    foreach (codes[i]) begin
      adopt(codes[i]);
      shot(1'b1, 0, lim(cur), 1);
    end
    for (m = 0; m < 4; m++) begin
      wr(8'h00, 32'h0000_0100 | m, 2'h0);
      rd(8'h00, 2'h0, v); chk(v, 32'h0000_0100 | m);
      g = m[1] ? 10 + int'(rnd() % 20) : 20;
      // The retrigger reaches the pin seven cycles after len hits g.
      shot(!m[0], g, m[1] ? g + 12 + 64 : 64, m[1] ? 2 : 1);
    end
    // Second power-up: a code that keeps moving must hold start-up open.
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    wr(8'h04, 32'h0000_0001, 2'h0);
    for (int n = 0; n < 250; n++) begin
      code_req <= n[0] ? 4'h3 : 4'h4;
      rd(8'h08, 2'h0, v);
      chk(v[2], 1'b0);
    end
    code_req <= 4'h2;
    for (int n = 0; n < 100 && !v[2]; n++) rd(8'h08, 2'h0, v);
    chk(v[7:2], 6'h09);
    chk(pulse_out, 1'b0);
    give_verdict();
  end
endmodule : one_shot_timer_tb_top
